// [shared/sfr_defs.svh]
// Register offsets, reset values and bit-address layout for the register bank
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define A_PTR_LO  8'h82
`define A_PTR_HI  8'h83
`define A_MCC     8'h8E
`define A_PSEL    8'h92
`define A_CLKC    8'hA3
`define A_IEXT    8'hA6
`define A_IRQ0    8'hA8
`define A_IRQ1    8'hB8
`define A_CAPEN   8'hC1
`define A_CAP1_LO 8'hC2
`define A_CAP1_HI 8'hC3
`define A_CAP2_LO 8'hC4
`define A_CAP2_HI 8'hC5
`define A_CAP3_LO 8'hC6
`define A_CAP3_HI 8'hC7
`define A_RCL     8'hCA
`define A_RCH     8'hCB
`define A_ACCU    8'hE0
`define A_CCS    8'hE8
`define A_ARC    8'hEF
`define A_AUX    8'hF0
`define A_KIN    8'hF1
`define A_IV     8'hF2
`define A_DIO    8'hF3
`define A_IA1    8'hF5
`define A_IA2    8'hF6
`define A_FST    8'hF8
`define A_FPC    8'hF9
`define A_FCMD   8'hFA

// ----------------------------------------
// Reset values and layout
// ----------------------------------------
`define RST_ZERO 8'h00
`define RST_MCC  8'h01
`define RST_CLKC 8'h80
`define RST_IEXT 8'h01
`define BIT_COL_MASK 8'h07
`define BIT_SFR_FLAG 8'h80
`define NUM_REGS 29

`endif

// [shared/sfr_pkg.sv]
// Types for the register bank
package sfr_pkg;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       bit_mode;
        logic [7:0] addr;
        logic       wbit;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] rdata;
    } sfr_rsp_t;
endpackage

// [rtl/sfr_cell.sv]
// One 8-bit register with byte write, bit write and fixed reset value
`timescale 1ns/100ps
module sfr_cell #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter bit         HAS_RESET = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       byte_we,
    input  wire logic       bit_we,
    input  wire logic [2:0] bit_sel,
    input  wire logic       bit_val,
    input  wire logic [7:0] wdata,
    output logic [7:0]      q
);
    logic [7:0] bit_merged;

    // Read-modify-write of one bit
    always_comb begin
        bit_merged          = q;
        bit_merged[bit_sel] = bit_val;
    end

    // Storage with optional reset
    always_ff @(posedge clk) begin
        if (!rst_n && HAS_RESET) begin
            q <= RESET_VAL;
        end else if (byte_we) begin
            q <= wdata;
        end else if (bit_we) begin
            q <= bit_merged;
        end
    end
endmodule

// [rtl/sfr_bank.sv]
// Special function register bank: address decode, bit access and reset values
`timescale 1ns/100ps
`include "sfr_defs.svh"
module sfr_bank (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire sfr_pkg::sfr_req_t req,
    output sfr_pkg::sfr_rsp_t     rsp,
    output logic [7:0]            mem_cycle_ctrl,
    output logic [7:0]            clock_ctrl,
    output logic [7:0]            irq_en0,
    output logic [7:0]            irq_en1
);
    import sfr_pkg::*;

    // ----------------------------------------
    // Register index
    // ----------------------------------------
    localparam int N = `NUM_REGS;
    // Data pointer, memory timing and pointer select
    localparam int IDX_PTR_LO  = 0;
    localparam int IDX_PTR_HI  = 1;
    localparam int IDX_MCC     = 2;
    localparam int IDX_PSEL    = 3;
    // Clock, interrupt extension and interrupt enables
    localparam int IDX_CLKC    = 4;
    localparam int IDX_IEXT    = 5;
    localparam int IDX_IRQ0    = 6;
    localparam int IDX_IRQ1    = 7;
    // Compare/capture and reload/capture registers
    localparam int IDX_CAPEN   = 8;
    localparam int IDX_CAP1_LO = 9;
    localparam int IDX_CAP1_HI = 10;
    localparam int IDX_CAP2_LO = 11;
    localparam int IDX_CAP2_HI = 12;
    localparam int IDX_CAP3_LO = 13;
    localparam int IDX_CAP3_HI = 14;
    localparam int IDX_RLD_LO  = 15;
    localparam int IDX_RLD_HI  = 16;
    // Accumulator, arithmetic control, aux operand and cipher
    localparam int IDX_ACCU    = 17;
    localparam int IDX_CCS     = 18;
    localparam int IDX_ARC     = 19;
    localparam int IDX_AUX     = 20;
    localparam int IDX_KIN     = 21;
    localparam int IDX_IV      = 22;
    localparam int IDX_DIO     = 23;
    localparam int IDX_IA1     = 24;
    localparam int IDX_IA2     = 25;
    // Flash status, protect config and command
    localparam int IDX_FST     = 26;
    localparam int IDX_FPC     = 27;
    localparam int IDX_FCMD    = 28;

    // ----------------------------------------
    // Address table
    // ----------------------------------------
    // Byte address of each cell, in index order; a slip here moves a register
    localparam logic [7:0] ADDRS [N] = '{
        `A_PTR_LO,  // IDX_PTR_LO
        `A_PTR_HI,  // IDX_PTR_HI
        `A_MCC,     // IDX_MCC
        `A_PSEL,    // IDX_PSEL
        `A_CLKC,    // IDX_CLKC
        `A_IEXT,    // IDX_IEXT
        `A_IRQ0,    // IDX_IRQ0
        `A_IRQ1,    // IDX_IRQ1
        `A_CAPEN,   // IDX_CAPEN
        `A_CAP1_LO, // IDX_CAP1_LO
        `A_CAP1_HI, // IDX_CAP1_HI
        `A_CAP2_LO, // IDX_CAP2_LO
        `A_CAP2_HI, // IDX_CAP2_HI
        `A_CAP3_LO, // IDX_CAP3_LO
        `A_CAP3_HI, // IDX_CAP3_HI
        `A_RCL,     // IDX_RLD_LO
        `A_RCH,     // IDX_RLD_HI
        `A_ACCU,    // IDX_ACCU
        `A_CCS,     // IDX_CCS
        `A_ARC,     // IDX_ARC
        `A_AUX,     // IDX_AUX
        `A_KIN,     // IDX_KIN
        `A_IV,      // IDX_IV
        `A_DIO,     // IDX_DIO
        `A_IA1,     // IDX_IA1
        `A_IA2,     // IDX_IA2
        `A_FST,     // IDX_FST
        `A_FPC,     // IDX_FPC
        `A_FCMD     // IDX_FCMD
    };

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Bit address: top bit set means register space, low three pick the bit
    wire logic [7:0] byte_addr  = req.bit_mode ? (req.addr & ~`BIT_COL_MASK) : req.addr;
    wire logic [2:0] bit_sel    = req.addr[2:0];
    wire logic       bit_space  = (req.addr & `BIT_SFR_FLAG) == `BIT_SFR_FLAG;
    wire logic       bit_ok     = !req.bit_mode || bit_space;
    logic [N-1:0]    hit;
    logic [N-1:0]    byte_we;
    logic [N-1:0]    bit_we;
    logic [7:0]      q [N];
    logic [7:0]      rd_mux;
    wire logic       any_hit    = |hit;
    wire logic       access     = req.rd || req.wr;

    // Bit accesses only reach registers whose address ends in 000
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_dec
            wire logic col0 = (ADDRS[gi] & `BIT_COL_MASK) == 8'h00;
            assign hit[gi]     = (byte_addr == ADDRS[gi]) && bit_ok && (!req.bit_mode || col0);
            assign byte_we[gi] = req.wr && !req.bit_mode && hit[gi];
            assign bit_we[gi]  = req.wr && req.bit_mode && hit[gi];
        end
    endgenerate

    // ----------------------------------------
    // Register cells
    // ----------------------------------------
    // Data pointer bytes and pointer select clear; memory timing starts at one
    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_ptr_lo (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_PTR_LO]),     .bit_we  (bit_we[IDX_PTR_LO]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_PTR_LO])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_ptr_hi (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_PTR_HI]),     .bit_we  (bit_we[IDX_PTR_HI]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_PTR_HI])
    );

    sfr_cell #(.RESET_VAL(`RST_MCC), .HAS_RESET(1'b1)) u_mcc (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_MCC]),        .bit_we  (bit_we[IDX_MCC]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_MCC])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_psel (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_PSEL]),       .bit_we  (bit_we[IDX_PSEL]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_PSEL])
    );

    // Clock control starts with its top bit set; both enables start cleared
    sfr_cell #(.RESET_VAL(`RST_CLKC), .HAS_RESET(1'b1)) u_clkc (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CLKC]),       .bit_we  (bit_we[IDX_CLKC]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CLKC])
    );

    sfr_cell #(.RESET_VAL(`RST_IEXT), .HAS_RESET(1'b1)) u_iext (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_IEXT]),       .bit_we  (bit_we[IDX_IEXT]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_IEXT])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_irq0 (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_IRQ0]),       .bit_we  (bit_we[IDX_IRQ0]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_IRQ0])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_irq1 (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_IRQ1]),       .bit_we  (bit_we[IDX_IRQ1]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_IRQ1])
    );

    // Capture enable, capture pairs and reload pair all clear
    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_capen (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CAPEN]),      .bit_we  (bit_we[IDX_CAPEN]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CAPEN])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_cap1_lo (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CAP1_LO]),    .bit_we  (bit_we[IDX_CAP1_LO]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CAP1_LO])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_cap1_hi (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CAP1_HI]),    .bit_we  (bit_we[IDX_CAP1_HI]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CAP1_HI])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_cap2_lo (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CAP2_LO]),    .bit_we  (bit_we[IDX_CAP2_LO]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CAP2_LO])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_cap2_hi (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CAP2_HI]),    .bit_we  (bit_we[IDX_CAP2_HI]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CAP2_HI])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_cap3_lo (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CAP3_LO]),    .bit_we  (bit_we[IDX_CAP3_LO]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CAP3_LO])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_cap3_hi (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CAP3_HI]),    .bit_we  (bit_we[IDX_CAP3_HI]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CAP3_HI])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_rld_lo (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_RLD_LO]),     .bit_we  (bit_we[IDX_RLD_LO]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_RLD_LO])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_rld_hi (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_RLD_HI]),     .bit_we  (bit_we[IDX_RLD_HI]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_RLD_HI])
    );

    // Accumulator, aux operand, arithmetic control and cipher cells clear
    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_accu (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_ACCU]),       .bit_we  (bit_we[IDX_ACCU]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_ACCU])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_ccs (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_CCS]),        .bit_we  (bit_we[IDX_CCS]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_CCS])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_arc (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_ARC]),        .bit_we  (bit_we[IDX_ARC]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_ARC])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_aux (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_AUX]),        .bit_we  (bit_we[IDX_AUX]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_AUX])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_kin (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_KIN]),        .bit_we  (bit_we[IDX_KIN]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_KIN])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_iv (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_IV]),         .bit_we  (bit_we[IDX_IV]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_IV])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_dio (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_DIO]),        .bit_we  (bit_we[IDX_DIO]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_DIO])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_ia1 (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_IA1]),        .bit_we  (bit_we[IDX_IA1]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_IA1])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_ia2 (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_IA2]),        .bit_we  (bit_we[IDX_IA2]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_IA2])
    );

    // Flash status and protect config have no reset; the command clears
    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b0)) u_fst (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_FST]),        .bit_we  (bit_we[IDX_FST]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_FST])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b0)) u_fpc (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_FPC]),        .bit_we  (bit_we[IDX_FPC]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_FPC])
    );

    sfr_cell #(.RESET_VAL(`RST_ZERO), .HAS_RESET(1'b1)) u_fcmd (
        .clk     (clk),                     .rst_n   (rst_n),
        .byte_we (byte_we[IDX_FCMD]),       .bit_we  (bit_we[IDX_FCMD]),
        .bit_sel (bit_sel),                 .bit_val (req.wbit),
        .wdata   (req.wdata),               .q       (q[IDX_FCMD])
    );

    // Read selection; bit reads return the addressed bit in bit 0
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (hit[i]) begin
                rd_mux = req.bit_mode ? {7'h00, q[i][bit_sel]} : q[i];
            end
        end
    end

    // ----------------------------------------
    // Response and control outputs
    // ----------------------------------------
    // Reserved locations answer with error and zero data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp            <= '0;
            mem_cycle_ctrl <= `RST_MCC;
            clock_ctrl     <= `RST_CLKC;
            irq_en0        <= `RST_ZERO;
            irq_en1        <= `RST_ZERO;
        end else begin
            rsp.valid      <= access;
            rsp.err        <= access && !any_hit;
            rsp.rdata      <= (req.rd && any_hit) ? rd_mux : 8'h00;
            mem_cycle_ctrl <= q[IDX_MCC];
            clock_ctrl     <= q[IDX_CLKC];
            irq_en0        <= q[IDX_IRQ0];
            irq_en1        <= q[IDX_IRQ1];
        end
    end
endmodule

// [sim/sfr_bank_props.sv]
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
module sfr_bank_props (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire sfr_pkg::sfr_req_t req,
    input  wire sfr_pkg::sfr_rsp_t rsp,
    input  wire logic [7:0]        mem_cycle_ctrl,
    input  wire logic [7:0]        clock_ctrl,
    input  wire logic [7:0]        irq_en0,
    input  wire logic [7:0]        irq_en1
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Access shapes, each answered one edge after it is taken
    sequence taken;
        req.rd || req.wr;
    endsequence
    sequence byte_wr(logic [7:0] a);
        req.wr && !req.bit_mode && req.addr == a;
    endsequence
    answer_pulse_a: assert property (taken |=> rsp.valid) else $error("no answer");
    reset_ctrl_a: assert property ($rose(rst_n) |-> mem_cycle_ctrl == 8'h01 && clock_ctrl == 8'h80)
        else $error("bad control reset");
    reset_irq_a: assert property ($rose(rst_n) |-> irq_en0 == 8'h00 && irq_en1 == 8'h00)
        else $error("bad enable reset");
    irq_write_a: assert property (byte_wr(8'hA8) |=> ##1 irq_en0 == $past(req.wdata, 2)) else $error("irq write");
    clk_write_a: assert property (byte_wr(8'hA3) |=> ##1 clock_ctrl == $past(req.wdata, 2)) else $error("clk write");
    bit_set_a: assert property (req.wr && req.bit_mode && req.addr == 8'hAA |=> ##1 irq_en0[2] == $past(req.wbit, 2))
        else $error("bit write");
    byte_ok_a: assert property (req.rd && !req.bit_mode && req.addr == 8'hA8 |=> !rsp.err) else $error("byte refused");
    bit_refuse_a: assert property ((req.rd || req.wr) && req.bit_mode && req.addr == 8'hC1 |=> rsp.err)
        else $error("bit taken");
    unmapped_err_a: assert property (req.rd && req.addr == 8'h84 |=> rsp.err && rsp.rdata == 8'h00)
        else $error("unmapped read");
endmodule
bind sfr_bank sfr_bank_props sfr_bank_props_inst (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
    .mem_cycle_ctrl(mem_cycle_ctrl), .clock_ctrl(clock_ctrl), .irq_en0(irq_en0), .irq_en1(irq_en1));

// [sim/core_model.sv]
// Processor core model issuing one direct access at a time
`timescale 1ns/100ps
module core_model (
    input  wire logic              clk,
    input  wire sfr_pkg::sfr_rsp_t rsp,
    output sfr_pkg::sfr_req_t      req
);
    import sfr_pkg::*;
    sfr_rsp_t last;
    initial req = '0;
    // Drive after an edge, held through the taking edge, answer read once settled
    task automatic access(input logic r, w, b, input logic [7:0] a, d);
        @(posedge clk);
        #1 req = '{r, w, b, a, d[0], d};
        @(posedge clk);
        #1 last = rsp;
        req = '0;
    endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the register bank
`timescale 1ns/100ps
module tb;
    import sfr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sfr_req_t req;
    sfr_rsp_t rsp;
    logic [7:0] mcc, clkc, ie0, ie1;
    int mismatches = 0;
    int n_tests = 0;
    logic [15:0] tbl [27] = '{16'h8200, 16'h8300, 16'h8E01, 16'h9200, 16'hA380, 16'hA601, 16'hA800, 16'hB800,
        16'hC100, 16'hC200, 16'hC300, 16'hC400, 16'hC500, 16'hC600, 16'hC700, 16'hCA00, 16'hCB00, 16'hE000,
        16'hE800, 16'hEF00, 16'hF000, 16'hF100, 16'hF200, 16'hF300, 16'hF500, 16'hF600, 16'hFA00};
    always #5 clk = ~clk;
    sfr_bank sfr_bank_inst (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .mem_cycle_ctrl(mcc),
        .clock_ctrl(clkc), .irq_en0(ie0), .irq_en1(ie1));
    core_model core_model_inst (.clk(clk), .rsp(rsp), .req(req));
    // Comparison of one answer, error flag above the data
    task automatic chk(input logic [9:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Comparison of one control output
    task automatic chk_out(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t output %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic r, w, b, input logic [7:0] a, d, input logic [8:0] e);
        core_model_inst.access(r, w, b, a, d);
        chk({core_model_inst.last.valid, core_model_inst.last.err, core_model_inst.last.rdata}, {1'b1, e});
    endtask
    task automatic check_reset();
        foreach (tbl[i]) xfer(1'b1, 1'b0, 1'b0, tbl[i][15:8], 8'h00, {1'b0, tbl[i][7:0]});
        chk_out(mcc, 8'h01);
        chk_out(clkc, 8'h80);
        chk_out(ie0, 8'h00);
        chk_out(ie1, 8'h00);
    endtask
    task automatic print_verdict();
        $display("Counts: %0d mismatches in %0d comparisons", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #50000;
        mismatches++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        check_reset();
        foreach (tbl[i]) xfer(1'b0, 1'b1, 1'b0, tbl[i][15:8], 8'h5A, 9'h000);
        foreach (tbl[i]) xfer(1'b1, 1'b0, 1'b0, tbl[i][15:8], 8'h00, 9'h05A);
        chk_out(mcc, 8'h5A);
        chk_out(clkc, 8'h5A);
        chk_out(ie0, 8'h5A);
        chk_out(ie1, 8'h5A);
        xfer(1'b0, 1'b1, 1'b0, 8'hF9, 8'hA5, 9'h000);
        xfer(1'b1, 1'b0, 1'b0, 8'hF9, 8'h00, 9'h0A5);
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        check_reset();
        xfer(1'b0, 1'b1, 1'b1, 8'hAA, 8'h01, 9'h000);
        xfer(1'b1, 1'b0, 1'b0, 8'hA8, 8'h00, 9'h004);
        xfer(1'b1, 1'b0, 1'b1, 8'hAA, 8'h00, 9'h001);
        chk_out(ie0, 8'h04);
        xfer(1'b0, 1'b1, 1'b1, 8'hC1, 8'h01, 9'h100);
        xfer(1'b1, 1'b0, 1'b0, 8'hC1, 8'h00, 9'h000);
        xfer(1'b1, 1'b0, 1'b0, 8'h84, 8'h00, 9'h100);
        print_verdict();
    end
endmodule
